// File: hw/sea_defines.svh
// Purpose: register offsets, field positions and reset values of the encoder axis
// Assumes: byte addresses on a 32-bit classic wishbone bus
// Notes:   included by its bare name
`ifndef SEA_DEFINES_SVH
`define SEA_DEFINES_SVH
`define SEA_OFF_CTRL      8'h00
`define SEA_OFF_STATUS    8'h04
`define SEA_OFF_ENC_CFG   8'h08
`define SEA_OFF_COUNT     8'h0c
`define SEA_OFF_ERR_CODE  8'h10
`define SEA_OFF_CL_CMD    8'h14
`define SEA_OFF_CL_STAT   8'h18
`define SEA_OFF_JOG_SET   8'h1c
`define SEA_OFF_JOG_ACT   8'h20
`define SEA_OFF_IRQ_STAT  8'h24
`define SEA_OFF_IRQ_CLR   8'h28
`define SEA_OFF_IRQ_EN    8'h2c
// ctrl fields
`define SEA_CTRL_MODE_REQ 0
`define SEA_CTRL_ERR_MODE 1
`define SEA_CTRL_EXT_CL   2
`define SEA_CTRL_JOG_GO   3
// status fields
`define SEA_ST_VIRTUAL    0
`define SEA_ST_RESTORED   1
`define SEA_ST_WARN       2
`define SEA_ST_ERR_FLAG   3
// encoder config fields
`define SEA_CFG_NUM_LSB   0
`define SEA_CFG_ABS       4
// interrupt status fields
`define SEA_IRQ_ERR       0
`define SEA_IRQ_WARN      1
`define SEA_IRQ_RESTORE   2
`define SEA_IRQ_W         3
// encoder numbers and reset values
`define SEA_ENC_MIN       4'h1
`define SEA_ENC_MAX_FULL  4'hc
`define SEA_ENC_MAX_SMALL 4'h8
`define SEA_RST_ENC_NUM   4'h1
`define SEA_RST_CTRL      4'h0
`endif

// File: hw/sea_pkg.sv
// Purpose: shared types of the encoder axis block
// Assumes: nothing beyond the defines header
// Notes:   mode state of the controller seen by the encoder axis
package sea_pkg;
   typedef enum logic {SEA_REAL, SEA_VIRTUAL} sea_mode_t;
   typedef enum logic {SEA_ERR_CONTINUE, SEA_ERR_CLUTCH_OFF} sea_err_mode_t;
endpackage

// File: hw/sea_cnt_if.sv
// Purpose: carrier between the axis top and its pulse counter
// Assumes: single clock domain
// Notes:   ctl drives enable and load, cnt returns the value
`timescale 1ns/1ns
interface sea_cnt_if;
   logic        count_en;
   logic        load;
   logic [31:0] load_val;
   logic [31:0] value;
   logic        step;
   modport ctl (output count_en, output load, output load_val, input value, input step);
   modport cnt (input count_en, input load, input load_val, output value, output step);
endinterface

// File: hw/sea_counter.sv
// Purpose: synchronise encoder pulses and accumulate a signed 32-bit current value
// Assumes: pulse and direction pins are asynchronous to clk_i
// Notes:   one count per rising pulse edge; load has priority over a step
`timescale 1ns/1ns
module sea_counter
   import sea_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic pulse_i,
   input  wire logic dir_i,
   sea_cnt_if.cnt    bus
);
   logic [1:0]  pls_sync_q;
   logic [1:0]  dir_sync_q;
   logic        pls_prev_q;
   logic [31:0] value_q;
   logic        rise;

   // two-stage synchronisers; only stage two is read
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pls_sync_q <= 2'h0;
         dir_sync_q <= 2'h0;
         pls_prev_q <= 1'b0;
      end else begin
         pls_sync_q <= {pls_sync_q[0], pulse_i};
         dir_sync_q <= {dir_sync_q[0], dir_i};
         pls_prev_q <= pls_sync_q[1];
      end
   end

   assign rise     = pls_sync_q[1] & ~pls_prev_q;
   assign bus.step = rise & bus.count_en;

   // no limit, stop or error input can hold the count; only absent pulses or a low count_en halt it
   // value only, no deviation counter or feedback count is kept
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         value_q <= 32'h0;
      end else if (bus.load) begin
         value_q <= bus.load_val;
      end else if (bus.step) begin
         value_q <= dir_sync_q[1] ? value_q - 32'h1 : value_q + 32'h1;
      end
   end
   assign bus.value = value_q;

   a_count_step: assert property (@(posedge clk_i) disable iff (rst_i)
      (bus.step && !bus.load) |=> value_q == ($past(dir_sync_q[1]) ? $past(value_q) - 32'h1
                                                                   : $past(value_q) + 32'h1))
      else $error("encoder count did not follow the pulse direction");
   a_count_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      (!bus.count_en && !bus.load) |=> $stable(value_q))
      else $error("count moved while counting was disabled");
endmodule

// File: hw/sea_clutch.sv
// Purpose: clutch status per output axis with error-driven drop and edge re-engage
// Assumes: cmd_i comes from a register on the same clock
// Notes:   status follows command until a drop; then only a command rising edge frees it
`timescale 1ns/1ns
module sea_clutch
   import sea_pkg::*;
#(
   parameter int N = 4
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic [N-1:0] cmd_i,
   input  wire logic         drop_i,
   output logic      [N-1:0] status_o
);
   logic [N-1:0] cmd_prev_q;
   logic [N-1:0] dropped_q;

   for (genvar i = 0; i < N; i++) begin : g_cl
      // drop forces status off; command bit itself is left alone
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            cmd_prev_q[i] <= 1'b0;
            dropped_q[i]  <= 1'b0;
         end else begin
            cmd_prev_q[i] <= cmd_i[i];
            if (drop_i) begin
               dropped_q[i] <= 1'b1;
            end else if (cmd_i[i] && !cmd_prev_q[i]) begin
               dropped_q[i] <= 1'b0;
            end
         end
      end
      assign status_o[i] = cmd_i[i] & ~dropped_q[i] & ~drop_i;

      a_reengage_edge: assert property (@(posedge clk_i) disable iff (rst_i)
         $fell(dropped_q[i]) |-> $past(cmd_i[i] && !cmd_prev_q[i]))
         else $error("clutch re-engaged without a command rising edge");
      a_drop_off: assert property (@(posedge clk_i) disable iff (rst_i)
         drop_i |=> !status_o[i] || (cmd_i[i] && !cmd_prev_q[i]))
         else $error("clutch status stayed on after an error drop");
   end
endmodule

// File: hw/sea_top.sv
// Purpose: synchronous encoder axis of a motion controller behind a wishbone slave
// Assumes: one 10 MHz clock, synchronous active-high reset, backup memory outside
// Notes:   encoder pins are synchronised in the counter; errors arrive on the same clock
`timescale 1ns/1ns
`include "sea_defines.svh"
module sea_top
   import sea_pkg::*;
#(
   parameter int N_AXES        = 4,
   parameter bit SMALL_VARIANT = 1'b0
) (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [7:0]        wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   output logic      [31:0]       wb_dat_o,
   output logic                   wb_ack_o,
   input  wire logic              enc_pulse_i,
   input  wire logic              enc_dir_i,
   input  wire logic              encoder_input_start_i,
   input  wire logic [31:0]       backup_value_i,
   input  wire logic              moved_off_i,
   output logic      [31:0]       backup_value_o,
   input  wire logic              major_err_i,
   input  wire logic [15:0]       major_err_code_i,
   input  wire logic [N_AXES-1:0] has_clutch_i,
   output logic      [N_AXES-1:0] axis_run_o,
   output logic      [N_AXES-1:0] clutch_status_o,
   output logic      [31:0]       jog_speed_o,
   output logic                   irq_o
);
   localparam logic [3:0] ENC_MAX = SMALL_VARIANT ? `SEA_ENC_MAX_SMALL : `SEA_ENC_MAX_FULL;

   sea_cnt_if cnt ();

   logic [3:0]              ctrl_q;
   logic [3:0]              enc_num_q;
   logic                    enc_abs_q;
   logic [N_AXES-1:0]       cl_cmd_q;
   logic [31:0]             jog_set_q;
   logic [31:0]             jog_act_q;
   logic                    jog_prev_q;
   logic [15:0]             err_code_q;
   logic                    err_flag_q;
   logic                    warn_q;
   logic                    restored_q;
   sea_mode_t               mode_q;
   logic [1:0]              start_sync_q;
   logic [1:0]              moved_sync_q;
   logic [`SEA_IRQ_W-1:0]   irq_stat_q;
   logic [`SEA_IRQ_W-1:0]   irq_en_q;
   logic                    ack_q;
   logic [31:0]             rdata_q;
   logic                    wr;
   logic                    rd;
   logic                    enter_virtual;
   logic                    restore;
   logic                    drop;
   logic                    ext_mode;
   logic [`SEA_IRQ_W-1:0]   irq_set;
   logic [3:0]              new_num;
   sea_err_mode_t           err_mode;

   // bus strobes: a read is taken on the request edge, a write lands on the acking edge
   // so that the register changes at the very edge at which the master sees ack
   assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
   assign rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
      end
   end
   assign wb_ack_o = ack_q;

   // pin synchronisers for the start input and the power-off motion strap
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         start_sync_q <= 2'h0;
         moved_sync_q <= 2'h0;
      end else begin
         start_sync_q <= {start_sync_q[0], encoder_input_start_i};
         moved_sync_q <= {moved_sync_q[0], moved_off_i};
      end
   end

   // control register; the error mode resets to continuation
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= `SEA_RST_CTRL;
      end else if (wr && wb_adr_i == `SEA_OFF_CTRL && wb_sel_i[0]) begin
         ctrl_q <= wb_dat_i[3:0];
      end
   end
   assign err_mode = ctrl_q[`SEA_CTRL_ERR_MODE] ? SEA_ERR_CLUTCH_OFF : SEA_ERR_CONTINUE;

   // encoder number must lie in the variant's range, else the write is dropped
   assign new_num = wb_dat_i[`SEA_CFG_NUM_LSB +: 4];
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         enc_num_q <= `SEA_RST_ENC_NUM;
         enc_abs_q <= 1'b0;
      end else if (wr && wb_adr_i == `SEA_OFF_ENC_CFG && wb_sel_i[0] &&
                   new_num >= `SEA_ENC_MIN && new_num <= ENC_MAX) begin
         enc_num_q <= new_num;
         enc_abs_q <= wb_dat_i[`SEA_CFG_ABS];
      end
   end

   // mode follows the switch request; falling request ends the axis
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_q <= SEA_REAL;
      end else begin
         mode_q <= ctrl_q[`SEA_CTRL_MODE_REQ] ? SEA_VIRTUAL : SEA_REAL;
      end
   end
   assign enter_virtual = ctrl_q[`SEA_CTRL_MODE_REQ] && mode_q == SEA_REAL;
   assign restore       = enter_virtual && !restored_q;

   // one restore per power cycle; motion while off raises the warning
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         restored_q <= 1'b0;
         warn_q     <= 1'b0;
      end else if (restore) begin
         restored_q <= 1'b1;
         warn_q     <= moved_sync_q[1];
      end
   end

   // incremental encoders only may be gated by the start input
   assign ext_mode     = ctrl_q[`SEA_CTRL_EXT_CL] & ~enc_abs_q;
   assign cnt.count_en = mode_q == SEA_VIRTUAL && (!ext_mode || start_sync_q[1]);
   assign cnt.load     = restore;
   assign cnt.load_val = backup_value_i;

   sea_counter u_counter (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .pulse_i (enc_pulse_i),
      .dir_i   (enc_dir_i),
      .bus     (cnt)
   );

   // current value mirrored to the battery-backed store every cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         backup_value_o <= 32'h0;
      end else begin
         backup_value_o <= cnt.value;
      end
   end

   // major error: continuation flags and stores, clutch-off drops clutches
   assign drop = major_err_i && err_mode == SEA_ERR_CLUTCH_OFF;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         err_code_q <= 16'h0;
         err_flag_q <= 1'b0;
      end else begin
         if (major_err_i) begin
            err_code_q <= major_err_code_i;
         end
         // set wins over the software clear written to the code register
         if (major_err_i && err_mode == SEA_ERR_CONTINUE) begin
            err_flag_q <= 1'b1;
         end else if (wr && wb_adr_i == `SEA_OFF_ERR_CODE) begin
            err_flag_q <= 1'b0;
         end
      end
   end

   // clutch command bits are only ever written by software
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cl_cmd_q <= '0;
      end else if (wr && wb_adr_i == `SEA_OFF_CL_CMD) begin
         cl_cmd_q <= wb_dat_i[N_AXES-1:0];
      end
   end

   sea_clutch #(.N(N_AXES)) u_clutch (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .cmd_i    (cl_cmd_q),
      .drop_i   (drop),
      .status_o (clutch_status_o)
   );

   // axes with no clutch keep running; in continuation nothing is stopped
   assign axis_run_o = ~has_clutch_i | clutch_status_o;

   // jog speed latched on jog start edge; later writes only touch the setting
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         jog_set_q  <= 32'h0;
         jog_act_q  <= 32'h0;
         jog_prev_q <= 1'b0;
      end else begin
         jog_prev_q <= ctrl_q[`SEA_CTRL_JOG_GO];
         if (wr && wb_adr_i == `SEA_OFF_JOG_SET) begin
            jog_set_q <= wb_dat_i;
         end
         if (ctrl_q[`SEA_CTRL_JOG_GO] && !jog_prev_q) begin
            jog_act_q <= jog_set_q;
         end
      end
   end
   assign jog_speed_o = jog_act_q;

   // sticky interrupt status; a new event beats a clear in the same cycle
   assign irq_set[`SEA_IRQ_ERR]     = major_err_i;
   assign irq_set[`SEA_IRQ_WARN]    = restore & moved_sync_q[1];
   assign irq_set[`SEA_IRQ_RESTORE] = restore;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat_q <= '0;
         irq_en_q   <= '0;
      end else begin
         if (wr && wb_adr_i == `SEA_OFF_IRQ_CLR) begin
            irq_stat_q <= (irq_stat_q & ~wb_dat_i[`SEA_IRQ_W-1:0]) | irq_set;
         end else begin
            irq_stat_q <= irq_stat_q | irq_set;
         end
         if (wr && wb_adr_i == `SEA_OFF_IRQ_EN) begin
            irq_en_q <= wb_dat_i[`SEA_IRQ_W-1:0];
         end
      end
   end
   assign irq_o = |(irq_stat_q & irq_en_q);

   // read mux; unmapped and write-only offsets read zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_q <= 32'h0;
      end else if (rd) begin
         case (wb_adr_i)
            `SEA_OFF_CTRL:     rdata_q <= {28'h0, ctrl_q};
            `SEA_OFF_STATUS:   rdata_q <= {28'h0, err_flag_q, warn_q, restored_q,
                                           mode_q == SEA_VIRTUAL};
            `SEA_OFF_ENC_CFG:  rdata_q <= {27'h0, enc_abs_q, enc_num_q};
            `SEA_OFF_COUNT:    rdata_q <= cnt.value;
            `SEA_OFF_ERR_CODE: rdata_q <= {16'h0, err_code_q};
            `SEA_OFF_CL_CMD:   rdata_q <= 32'(cl_cmd_q);
            `SEA_OFF_CL_STAT:  rdata_q <= 32'(clutch_status_o);
            `SEA_OFF_JOG_SET:  rdata_q <= jog_set_q;
            `SEA_OFF_JOG_ACT:  rdata_q <= jog_act_q;
            `SEA_OFF_IRQ_STAT: rdata_q <= 32'(irq_stat_q);
            `SEA_OFF_IRQ_EN:   rdata_q <= 32'(irq_en_q);
            default:           rdata_q <= 32'h0;
         endcase
      end
   end
   assign wb_dat_o = rdata_q;

   a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held for more than one cycle");
   a_restore_once: assert property (@(posedge clk_i) disable iff (rst_i)
      restored_q |=> restored_q && !cnt.load)
      else $error("backup value reloaded twice in one power cycle");
   a_restore_value: assert property (@(posedge clk_i) disable iff (rst_i)
      restore |=> cnt.value == $past(backup_value_i) && restored_q)
      else $error("restored value not loaded on first virtual entry");
   a_warn_moved: assert property (@(posedge clk_i) disable iff (rst_i)
      restore |=> warn_q == $past(moved_sync_q[1]))
      else $error("power-off motion warning wrong after restore");
   a_cont_flag: assert property (@(posedge clk_i) disable iff (rst_i)
      (major_err_i && err_mode == SEA_ERR_CONTINUE) |=>
      err_flag_q && err_code_q == $past(major_err_code_i) && !$past(drop))
      else $error("continuation error not flagged or code not stored");
   a_cmd_kept: assert property (@(posedge clk_i) disable iff (rst_i)
      (drop && !(wr && wb_adr_i == `SEA_OFF_CL_CMD)) |=> $stable(cl_cmd_q))
      else $error("clutch command changed by an error drop");
   a_no_clutch_run: assert property (@(posedge clk_i) disable iff (rst_i)
      drop |-> clutch_status_o == '0 && axis_run_o == ~has_clutch_i)
      else $error("clutchless axis stopped or clutch survived a drop");
   a_real_stops: assert property (@(posedge clk_i) disable iff (rst_i)
      (mode_q == SEA_REAL) |-> !cnt.count_en)
      else $error("encoder counted in real mode");
   a_ext_gate: assert property (@(posedge clk_i) disable iff (rst_i)
      (ext_mode && !start_sync_q[1]) |-> !cnt.count_en)
      else $error("external clutch mode counted without start input");
   a_jog_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      !(ctrl_q[`SEA_CTRL_JOG_GO] && !jog_prev_q) |=> $stable(jog_act_q))
      else $error("jog speed changed outside its start edge");
   a_enc_range: assert property (@(posedge clk_i) disable iff (rst_i)
      enc_num_q >= `SEA_ENC_MIN && enc_num_q <= ENC_MAX)
      else $error("encoder number out of range");
endmodule

// File: dv/sea_enc_model.sv
// Purpose: incremental encoder model driving pulse and direction pins
// Assumes: one clock; pins change just after a rising edge
// Notes:   hold sets pulse high and low time in clocks, 2 or more
`timescale 1ns/1ns
module sea_enc_model (
   input  wire logic clk_i,
   output logic      pulse_o,
   output logic      dir_o
);
   // pins idle low until the first burst
   initial begin
      pulse_o = 1'b0;
      dir_o   = 1'b0;
   end

   // direction settles before the first edge so the synchroniser never sees skew
   task automatic burst(input int n, input logic down, input int hold);
      @(posedge clk_i);
      dir_o <= down;
      repeat (3) @(posedge clk_i);
      for (int i = 0; i < n; i++) begin
         pulse_o <= 1'b1;
         repeat (hold) @(posedge clk_i);
         pulse_o <= 1'b0; // line stays low once pulses cease
         repeat (hold) @(posedge clk_i);
      end
   endtask
endmodule

// File: dv/sea_top_bench.sv
// Purpose: self-checking bench for the encoder axis through its wishbone registers
// Assumes: 10 MHz clock, sync reset held 20 cycles, 4 output axes
// Notes:   bus task waits on ack; a watchdog ends any hang
`timescale 1ns/1ns
`include "sea_defines.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
   $display("Error %s expected %h seen %h", nm, e, g); end end
module sea_top_bench;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, q, bkp_o, manual_jog;
   logic [31:0] rdat_s, qs;
   logic        ack, irq, pulse, dir, start = 1'b0, moved = 1'b0;
   logic        merr = 1'b0;
   logic [15:0] mcode = 16'h0;
   logic [31:0] bkp = 32'h0;
   logic [3:0]  has_cl = 4'h3, run, cl_st;
   int          n_tests = 0, n_mismatch = 0, cycles = 0;

   // 100 ns period
   always #50 clk_i = ~clk_i;

   sea_enc_model enc_u (.clk_i(clk_i), .pulse_o(pulse), .dir_o(dir));

   sea_top #(.N_AXES(4), .SMALL_VARIANT(1'b0)) dut_u (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .enc_pulse_i(pulse), .enc_dir_i(dir), .encoder_input_start_i(start),
      .backup_value_i(bkp), .moved_off_i(moved), .backup_value_o(bkp_o),
      .major_err_i(merr), .major_err_code_i(mcode), .has_clutch_i(has_cl),
      .axis_run_o(run), .clutch_status_o(cl_st), .jog_speed_o(manual_jog), .irq_o(irq));

   // smaller variant on the same bus; only its read data is watched
   sea_top #(.N_AXES(4), .SMALL_VARIANT(1'b1)) dut_s (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat_s), .wb_ack_o(),
      .enc_pulse_i(pulse), .enc_dir_i(dir), .encoder_input_start_i(start),
      .backup_value_i(bkp), .moved_off_i(moved), .backup_value_o(),
      .major_err_i(merr), .major_err_code_i(mcode), .has_clutch_i(has_cl),
      .axis_run_o(), .clutch_status_o(), .jog_speed_o(), .irq_o());

   task final_report;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // watchdog: the sequence needs a few hundred cycles
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         final_report;
      end
   end

   // one classic cycle; request held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      q  = rdat;
      qs = rdat_s;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      `CHK(nm, e, q)
   endtask

   // single-cycle error pulse with its code
   task automatic err(input logic [15:0] c);
      @(posedge clk_i);
      merr  <= 1'b1;
      mcode <= c;
      @(posedge clk_i);
      merr <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask

   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      rd("status", `SEA_OFF_STATUS, 32'h0);
      rd("enc_cfg", `SEA_OFF_ENC_CFG, 32'h1);
      `CHK("enc_cfg_small", 32'h1, qs)
      rd("unmapped", 8'h40, 32'h0);
      `CHK("run", 4'hc, run)
      `CHK("irq", 1'b0, irq)
      // encoder numbers: 12 with absolute kept, 13 and 0 refused; small variant stops at 8
      wb(1'b1, `SEA_OFF_ENC_CFG, 32'h1c);
      rd("enc_cfg", `SEA_OFF_ENC_CFG, 32'h1c);
      wb(1'b1, `SEA_OFF_ENC_CFG, 32'h0d);
      wb(1'b1, `SEA_OFF_ENC_CFG, 32'h00);
      rd("enc_cfg", `SEA_OFF_ENC_CFG, 32'h1c);
      `CHK("enc_cfg_small", 32'h1, qs)
      wb(1'b1, `SEA_OFF_ENC_CFG, 32'h08);
      rd("enc_cfg", `SEA_OFF_ENC_CFG, 32'h08);
      `CHK("enc_cfg_small", 32'h8, qs)
      wb(1'b1, `SEA_OFF_ENC_CFG, 32'h0c);
      $display("test config done");
      // restore on first switch to virtual, with motion while off
      bkp   <= 32'hffff_fffe;
      moved <= 1'b1;
      wb(1'b1, `SEA_OFF_IRQ_EN, 32'h1);
      wb(1'b1, `SEA_OFF_CTRL, 32'h1);
      repeat (4) @(posedge clk_i);
      rd("count", `SEA_OFF_COUNT, 32'hffff_fffe);
      rd("status", `SEA_OFF_STATUS, 32'h7);
      rd("irq_stat", `SEA_OFF_IRQ_STAT, 32'h6);
      `CHK("irq", 1'b0, irq)
      enc_u.burst(5, 1'b0, 2);
      repeat (8) @(posedge clk_i);
      rd("count", `SEA_OFF_COUNT, 32'h3);
      enc_u.burst(4, 1'b1, 6);
      repeat (20) @(posedge clk_i);
      rd("count", `SEA_OFF_COUNT, 32'hffff_ffff);
      $display("test restore done");
      // continuation: flag, code, interrupt; clear paths
      err(16'h0a5c);
      rd("status", `SEA_OFF_STATUS, 32'hf);
      rd("err_code", `SEA_OFF_ERR_CODE, 32'h0a5c);
      `CHK("irq", 1'b1, irq)
      wb(1'b1, `SEA_OFF_IRQ_CLR, 32'h1);
      wb(1'b1, `SEA_OFF_ERR_CODE, 32'h0);
      rd("status", `SEA_OFF_STATUS, 32'h7);
      `CHK("irq", 1'b0, irq)
      $display("test continuation done");
      // clutch off: all status drops, command bits stay, edge re-engages
      wb(1'b1, `SEA_OFF_CTRL, 32'h3);
      wb(1'b1, `SEA_OFF_CL_CMD, 32'hf);
      rd("cl_stat", `SEA_OFF_CL_STAT, 32'hf);
      err(16'h0123);
      `CHK("cl_st", 4'h0, cl_st)
      `CHK("run", 4'hc, run)
      rd("cl_cmd", `SEA_OFF_CL_CMD, 32'hf);
      rd("status", `SEA_OFF_STATUS, 32'h7);
      wb(1'b1, `SEA_OFF_CL_CMD, 32'hf);
      rd("cl_stat", `SEA_OFF_CL_STAT, 32'h0);
      wb(1'b1, `SEA_OFF_CL_CMD, 32'h0);
      wb(1'b1, `SEA_OFF_CL_CMD, 32'hf);
      rd("cl_stat", `SEA_OFF_CL_STAT, 32'hf);
      `CHK("run", 4'hf, run)
      $display("test clutch done");
      // jog speed latched on start edge only
      wb(1'b1, `SEA_OFF_JOG_SET, 32'h1234);
      wb(1'b1, `SEA_OFF_CTRL, 32'hb);
      wb(1'b1, `SEA_OFF_JOG_SET, 32'h55);
      rd("jog_act", `SEA_OFF_JOG_ACT, 32'h1234);
      `CHK("jog", 32'h1234, manual_jog)
      $display("test jog done");
      // external clutch mode counts only with the start input high
      wb(1'b1, `SEA_OFF_CTRL, 32'h5);
      enc_u.burst(2, 1'b0, 2);
      repeat (8) @(posedge clk_i);
      rd("count", `SEA_OFF_COUNT, 32'hffff_ffff);
      start <= 1'b1;
      enc_u.burst(2, 1'b0, 2);
      repeat (8) @(posedge clk_i);
      rd("count", `SEA_OFF_COUNT, 32'h1);
      $display("test external start done");
      // back to real: counting ends; second switch restores nothing
      wb(1'b1, `SEA_OFF_CTRL, 32'h0);
      enc_u.burst(3, 1'b0, 2);
      repeat (8) @(posedge clk_i);
      rd("count", `SEA_OFF_COUNT, 32'h1);
      bkp <= 32'h0000_7777;
      wb(1'b1, `SEA_OFF_CTRL, 32'h1);
      repeat (4) @(posedge clk_i);
      rd("count", `SEA_OFF_COUNT, 32'h1);
      `CHK("backup", 32'h1, bkp_o)
      $display("test mode end done");
      final_report;
   end
endmodule
